// file: rtl/fbpam_params.svh
// Register offsets, reset values and field positions of the four-bit address/port block
`ifndef FBPAM_PARAMS_SVH
`define FBPAM_PARAMS_SVH
`define FBPAM_ADDR_DIRECTION 16'hFFC8
`define FBPAM_ADDR_LATCH 16'hFFCA
`define FBPAM_ADDR_PULLUP 16'hFFDB
`define FBPAM_DIR_RESET_EXP 8'hFF
`define FBPAM_DIR_RESET_SC 8'hF0
`define FBPAM_LATCH_RESET 8'hF0
`define FBPAM_PULLUP_RESET 8'hF0
`define FBPAM_UPPER_ONES 4'hF
`define FBPAM_READ_ONES 8'hFF
`define FBPAM_PIN_MSB 3
`endif

// file: rtl/fbpam_pkg.sv
// Types of the four-bit address/port block
package fbpam_pkg;
  typedef enum logic [2:0] {
    FBPAM_MODE_1 = 3'b001,
    FBPAM_MODE_3 = 3'b011,
    FBPAM_MODE_5 = 3'b101,
    FBPAM_MODE_6 = 3'b110,
    FBPAM_MODE_7 = 3'b111
  } fbpam_mode_t;
  typedef enum logic [1:0] {
    FBPAM_RUN = 2'b00,
    FBPAM_SW_STANDBY = 2'b01,
    FBPAM_HW_STANDBY = 2'b10
  } fbpam_power_t;
  typedef struct packed {
    logic [3:0] direction;
    logic [3:0] latch;
    logic [3:0] pullup_ctl;
    logic [3:0] pin_meta;
    logic [3:0] pin_sync;
    logic [7:0] rdata;
    logic [3:0] pin_out;
    logic [3:0] pin_oe;
    logic [3:0] pullup_on;
    logic expanded;
  } fbpam_state_t;
endpackage

// file: rtl/fbpam_port.sv
// Four-bit port whose pins can carry the upper address lines
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/100ps
`include "fbpam_params.svh"
module fbpam_port (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire fbpam_pkg::fbpam_mode_t mode_in,
  input wire fbpam_pkg::fbpam_power_t power_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [3:0] upper_address_lines_in,
  input wire logic [3:0] port_pins_in,
  output logic [7:0] rdata_out,
  output logic [3:0] port_pins_out,
  output logic [3:0] port_pins_oe_out,
  output logic [3:0] pin_pullup_enables_out
);
  import fbpam_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  fbpam_state_t st;
  fbpam_state_t next_st;
  logic is_exp;
  logic init_now;

  always_comb begin
    is_exp = (mode_in == FBPAM_MODE_1) || (mode_in == FBPAM_MODE_3);
    init_now = !reset_n_in || (power_in == FBPAM_HW_STANDBY);
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.pin_meta = port_pins_in;
    next_st.pin_sync = st.pin_meta;
    next_st.expanded = is_exp;
    next_st.rdata = 8'h00;
    if (init_now) begin
      next_st.direction = is_exp ? 4'(`FBPAM_DIR_RESET_EXP) : 4'(`FBPAM_DIR_RESET_SC);
      next_st.latch = 4'(`FBPAM_LATCH_RESET);
      next_st.pullup_ctl = 4'(`FBPAM_PULLUP_RESET);
      next_st.pin_oe = 4'h0;
      next_st.pin_out = 4'h0;
      next_st.pullup_on = 4'h0;
    end else if (power_in == FBPAM_SW_STANDBY) begin
      next_st.pin_oe = st.pin_oe;
    end else begin
      if (wr_in) begin
        if (addr_in == `FBPAM_ADDR_DIRECTION && !is_exp) begin
          next_st.direction = wdata_in[3:0];
        end
        if (addr_in == `FBPAM_ADDR_LATCH) begin
          next_st.latch = wdata_in[3:0];
        end
        if (addr_in == `FBPAM_ADDR_PULLUP) begin
          next_st.pullup_ctl = wdata_in[3:0];
        end
      end
      if (rd_in) begin
        case (addr_in)
          `FBPAM_ADDR_DIRECTION: next_st.rdata = `FBPAM_READ_ONES;
          `FBPAM_ADDR_LATCH: next_st.rdata = {`FBPAM_UPPER_ONES,
            (st.direction & st.latch) | (~st.direction & st.pin_sync)};
          `FBPAM_ADDR_PULLUP: next_st.rdata = {`FBPAM_UPPER_ONES, st.pullup_ctl};
          default: next_st.rdata = 8'h00;
        endcase
      end
      if (is_exp) begin
        next_st.pin_oe = 4'hF;
        next_st.pin_out = upper_address_lines_in;
        next_st.pullup_on = 4'h0;
      end else begin
        next_st.pin_oe = st.direction;
        next_st.pin_out = (mode_in == FBPAM_MODE_5) ? upper_address_lines_in : st.latch;
        next_st.pullup_on = st.pullup_ctl & ~st.direction;
      end
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    st <= next_st;
  end

  always_comb begin
    rdata_out = st.rdata;
    port_pins_out = st.pin_out;
    port_pins_oe_out = st.pin_oe;
    pin_pullup_enables_out = st.pullup_on;
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);

  exp_drives_a: assert property (is_exp && power_in == FBPAM_RUN ##1 power_in != FBPAM_HW_STANDBY
    |-> st.pin_oe == 4'hF)
    else $error("expanded mode pins not all driven");
  sc_dir_oe_a: assert property (!is_exp && power_in == FBPAM_RUN
    |=> st.pin_oe == $past(st.direction))
    else $error("pin enable differs from direction");
  hw_release_a: assert property (power_in == FBPAM_HW_STANDBY
    |=> st.pin_oe == 4'h0 && st.pullup_on == 4'h0)
    else $error("pins or pull-ups active after hardware standby");
  out_read_a: assert property (rd_in && addr_in == `FBPAM_ADDR_LATCH && power_in == FBPAM_RUN
    |=> (rdata_out[3:0] & $past(st.direction)) == ($past(st.latch) & $past(st.direction)))
    else $error("output pin read not from latch");
  pullup_read_a: assert property (rd_in && addr_in == `FBPAM_ADDR_PULLUP && power_in == FBPAM_RUN
    |=> rdata_out == {4'hF, $past(st.pullup_ctl)})
    else $error("pull-up control read wrong");
  mode5_addr_a: assert property (mode_in == FBPAM_MODE_5 && power_in == FBPAM_RUN
    |=> power_in != FBPAM_RUN || st.pin_out == $past(upper_address_lines_in))
    else $error("mode 5 address not driven");
  dir_reset_a: assert property (power_in == FBPAM_HW_STANDBY && !is_exp
    |=> st.direction == 4'h0 && st.pullup_on == 4'h0)
    else $error("direction not cleared by standby");
  exp_dir_lock_a: assert property (is_exp && $stable(mode_in) && power_in != FBPAM_HW_STANDBY
    |=> $stable(st.direction))
    else $error("direction changed in expanded mode");
  sw_hold_a: assert property (power_in == FBPAM_SW_STANDBY |=> $stable(st.latch)
    && $stable(st.pullup_ctl) && $stable(st.pin_oe) && $stable(st.pin_out))
    else $error("state changed in software standby");
  dir_read_a: assert property (rd_in && addr_in == `FBPAM_ADDR_DIRECTION && power_in == FBPAM_RUN
    |=> rdata_out == 8'hFF)
    else $error("direction read not all ones");
  latch_read_a: assert property (rd_in && addr_in == `FBPAM_ADDR_LATCH && power_in == FBPAM_RUN
    |=> rdata_out[7:4] == 4'hF)
    else $error("reserved bits not ones");
  exp_pullup_a: assert property (st.expanded |-> st.pullup_on == 4'h0)
    else $error("pull-up on in expanded mode");
  pullup_gate_a: assert property ((st.pullup_on & st.pin_oe) == 4'h0 || st.expanded)
    else $error("pull-up on while driving");

  sw_standby_c: cover property (power_in == FBPAM_RUN ##1 power_in == FBPAM_SW_STANDBY);
  mode5_out_c: cover property (mode_in == FBPAM_MODE_5 && st.pin_oe != 4'h0);
  pullup_c: cover property (st.pullup_on != 4'h0);
endmodule // fbpam_port

// file: test/fbpam_board.sv
// Board model of the levels seen at the four port pins
`timescale 1ns/100ps
module fbpam_board (
  input wire logic [3:0] drive_in,
  input wire logic [3:0] oe_in,
  input wire logic [3:0] pullup_in,
  input wire logic [3:0] ext_en_in,
  input wire logic [3:0] ext_in,
  output logic [3:0] level_out
);
  // Released lines take ext_in where ext_en_in is set, else go high under a pull-up, else away from the last drive
  assign level_out = (oe_in & drive_in) | (~oe_in & ext_en_in & ext_in) |
    (~oe_in & ~ext_en_in & (pullup_in | ~drive_in));
endmodule // fbpam_board

// file: test/tb.sv
// Self-checking bench of the four-bit address/port block
`timescale 1ns/100ps
`include "fbpam_params.svh"
module tb;
  import fbpam_pkg::*;
  logic sys_clk_in = 0, reset_n_in = 0, wr = 0, rd = 0;
  fbpam_mode_t mode = FBPAM_MODE_7;
  fbpam_power_t pwr = FBPAM_RUN;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00, rdata;
  logic [3:0] upper = 4'hA, ext = 4'h6, ext_en = 4'hF, pin_in, pin_out, pin_oe, pull;
  int n_errors = 0, n_tests = 0;
  always #5 sys_clk_in = ~sys_clk_in;
  fbpam_port u_dut (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .mode_in(mode), .power_in(pwr),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .upper_address_lines_in(upper),
    .port_pins_in(pin_in), .rdata_out(rdata), .port_pins_out(pin_out), .port_pins_oe_out(pin_oe),
    .pin_pullup_enables_out(pull));
  fbpam_board u_board (.drive_in(pin_out), .oe_in(pin_oe), .pullup_in(pull), .ext_en_in(ext_en),
    .ext_in(ext), .level_out(pin_in));
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk_in) begin addr <= a; wdata <= d; wr <= 1'b1; end
    @(posedge sys_clk_in) wr <= 1'b0;
  endtask
  task rd_reg(input logic [15:0] a, input logic [7:0] exp);
    @(posedge sys_clk_in) begin addr <= a; rd <= 1'b1; end
    @(posedge sys_clk_in) rd <= 1'b0;
    @(negedge sys_clk_in) chk(rdata, exp);
  endtask
  task settle;
    repeat (4) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
  endtask
  task restart(input fbpam_mode_t m);
    @(posedge sys_clk_in) begin mode <= m; reset_n_in <= 1'b0; end
    repeat (5) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    settle;
  endtask
  task complete_run;
    if (n_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task expanded(input fbpam_mode_t m, input logic [3:0] a);
    restart(m);
    @(posedge sys_clk_in) upper <= a;
    wr_reg(`FBPAM_ADDR_DIRECTION, 8'h00);
    wr_reg(`FBPAM_ADDR_PULLUP, 8'h0F);
    settle;
    chk({pin_oe, pin_out}, {4'hF, a});
    chk({4'h0, pull}, 8'h00);
    rd_reg(`FBPAM_ADDR_DIRECTION, 8'hFF);
    rd_reg(`FBPAM_ADDR_PULLUP, 8'hFF);
  endtask
  task mode_five;
    restart(FBPAM_MODE_5);
    chk({pin_oe, pull}, 8'h00);
    rd_reg(`FBPAM_ADDR_LATCH, {4'hF, ext});
    wr_reg(`FBPAM_ADDR_DIRECTION, 8'h05);
    wr_reg(`FBPAM_ADDR_PULLUP, 8'h0F);
    settle;
    chk({pin_oe, pin_out & 4'h5, pull}, {4'h5, upper & 4'h5, 4'hA});
  endtask
  task single_chip(input fbpam_mode_t m);
    restart(m);
    @(posedge sys_clk_in) ext_en <= 4'hE;
    wr_reg(`FBPAM_ADDR_LATCH, 8'hFC);
    wr_reg(`FBPAM_ADDR_DIRECTION, 8'h0A);
    wr_reg(`FBPAM_ADDR_PULLUP, 8'h03);
    settle;
    chk({pin_oe, pin_out & 4'hA, pull}, {4'hA, 4'h8, 4'h1});
    rd_reg(`FBPAM_ADDR_LATCH, 8'hFD);
    @(posedge sys_clk_in) pwr <= FBPAM_SW_STANDBY;
    wr_reg(`FBPAM_ADDR_LATCH, 8'h03);
    settle;
    chk({pin_oe, pin_out & 4'hA, pull}, {4'hA, 4'h8, 4'h1});
    @(posedge sys_clk_in) pwr <= FBPAM_RUN;
    rd_reg(`FBPAM_ADDR_LATCH, 8'hFD);
    @(posedge sys_clk_in) begin pwr <= FBPAM_HW_STANDBY; ext_en <= 4'hF; end
    settle;
    chk({pin_oe, pull}, 8'h00);
    @(posedge sys_clk_in) pwr <= FBPAM_RUN;
    settle;
    rd_reg(`FBPAM_ADDR_PULLUP, 8'hF0);
    rd_reg(`FBPAM_ADDR_LATCH, {4'hF, ext});
  endtask
  initial begin
    expanded(FBPAM_MODE_1, 4'h5);
    expanded(FBPAM_MODE_3, 4'hA);
    mode_five;
    single_chip(FBPAM_MODE_6);
    single_chip(FBPAM_MODE_7);
    complete_run;
  end
endmodule // tb
